// file: core/event_code_pkg.sv
// Package of event-type codes, cause codes, record layout and the line-state enumeration for the event record encoder
package event_code_pkg;

    // ------------------------------------------------------------
    // Record layout
    // ------------------------------------------------------------
    localparam int STAMP_BYTES = 4;
    localparam int RECORD_BYTES = 6;
    localparam int RECORD_BITS = RECORD_BYTES * 8;

    // ------------------------------------------------------------
    // Event-type identifiers
    // ------------------------------------------------------------
    localparam logic [7:0] EVT_DUMMY = 8'h00;
    localparam logic [7:0] EVT_END_XFER = 8'h01;
    localparam logic [7:0] EVT_PREV_END_XFER = 8'h02;
    localparam logic [7:0] EVT_FAILED_INIT = 8'h03;
    localparam logic [7:0] EVT_GOOD_INIT = 8'h04;
    localparam logic [7:0] EVT_DS_INIT_RATE = 8'h05;
    localparam logic [7:0] EVT_US_INIT_RATE = 8'h06;
    localparam logic [7:0] EVT_DS_RATE_ADAPT = 8'h0B;
    localparam logic [7:0] EVT_US_RATE_ADAPT = 8'h0C;
    localparam logic [7:0] EVT_DS_RATE_SAVE = 8'h0D;
    localparam logic [7:0] EVT_US_RATE_SAVE = 8'h0E;
    localparam logic [7:0] EVT_RESERVED_LO = 8'h11;
    localparam logic [7:0] EVT_RESERVED_HI = 8'h7F;
    localparam logic [7:0] EVT_VENDOR_LO = 8'h80;

    // ------------------------------------------------------------
    // End-of-data-transfer cause codes
    // ------------------------------------------------------------
    localparam logic [7:0] CAUSE_NONE = 8'h00;
    localparam logic [7:0] CAUSE_CO_HOST = 8'h01;
    localparam logic [7:0] CAUSE_REMOTE_HOST = 8'h02;
    localparam logic [7:0] CAUSE_LOSS_SIGNAL = 8'h03;
    localparam logic [7:0] CAUSE_LOSS_FRAME = 8'h04;
    localparam logic [7:0] CAUSE_SEV_ERR_SEC = 8'h05;
    localparam logic [7:0] CAUSE_LOSS_MARGIN = 8'h06;
    localparam logic [7:0] CAUSE_SUBLAYER_SYNC = 8'h07;
    localparam logic [7:0] CAUSE_SAVE_LIMIT = 8'h08;
    localparam logic [7:0] CAUSE_SAVE_TIMEOUT = 8'h09;
    localparam logic [7:0] CAUSE_OVERHEAD_NORESP = 8'h0A;
    localparam logic [7:0] CAUSE_VEND_NEAR_BER = 8'h0B;
    localparam logic [7:0] CAUSE_VEND_FAR_BER = 8'h0C;
    localparam logic [7:0] CAUSE_POLICY1_BER = 8'h0D;

    // Reinit policy values
    localparam logic POLICY_ZERO = 1'b0;
    localparam logic POLICY_ONE = 1'b1;

    // ------------------------------------------------------------
    // Event-source indices (input vector bit positions)
    // ------------------------------------------------------------
    localparam int SRC_PREV_END = 0;
    localparam int SRC_FAILED_INIT = 1;
    localparam int SRC_GOOD_INIT = 2;
    localparam int SRC_DS_INIT = 3;
    localparam int SRC_US_INIT = 4;
    localparam int SRC_DS_ADAPT = 5;
    localparam int SRC_US_ADAPT = 6;
    localparam int SRC_DS_SAVE = 7;
    localparam int SRC_US_SAVE = 8;
    localparam int SRC_END_XFER = 9;
    localparam int NUM_SRC = 10;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LINE_OTHER,
        LINE_DATA_XFER,
        LINE_QUIET
    } line_state_type;

    // Departure triggers, one bit per cause
    typedef struct packed {
        logic co_host;
        logic remote_host;
        logic loss_signal;
        logic loss_frame;
        logic sev_err_sec;
        logic loss_margin;
        logic sublayer_sync;
        logic save_limit;
        logic save_timeout;
        logic overhead_noresp;
        logic vend_near_ber;
        logic vend_far_ber;
        logic policy1_ber;
    } trigger_type;

    // One six-byte record
    typedef struct packed {
        logic [STAMP_BYTES*8-1:0] stamp;
        logic [7:0] event_type;
        logic [7:0] event_data;
    } record_type;

endpackage

// file: core/event_record_code_encoder.sv
// Event record encoder: assigns event-type and cause codes and emits six-byte log records
// Notes
// Line state, triggers, policy and event strobes come from logic on i_clk, so no synchroniser.
// Records leave on a valid/ready write; valid and record hold until the buffer accepts.
// Hazards and limits:
// - Triggers and reinit policy are sampled in the cycle of the quiet transition.
// - A transition with no recognised trigger logs nothing.
// - The stamp is the one captured at the tick that closes the second.
// - A buffer that stalls across a further tick gives the late records the newer stamp.
// - A slot still pending at the next tick is overwritten with the newer second's data if that second saw the event.
// - Optional types are left out by clearing their IMPLEMENTED bit.
// - Pending records leave lowest source first, one per accept.
//
module event_record_code_encoder #(
    parameter logic [event_code_pkg::NUM_SRC-1:0] IMPLEMENTED = '1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Transceiver state and timing
    input wire event_code_pkg::line_state_type i_line_state,
    input wire logic i_second_tick,
    input wire logic [event_code_pkg::STAMP_BYTES*8-1:0] i_stamp,
    input wire logic i_reinit_policy,
    // Departure triggers from monitors and hosts
    input wire event_code_pkg::trigger_type i_trigger,
    // Other event strobes, one bit per source, with data bytes
    input wire logic [event_code_pkg::NUM_SRC-1:0] i_event,
    input wire logic [event_code_pkg::NUM_SRC*8-1:0] i_event_data,
    // Record write to the buffer
    output logic o_rec_valid,
    output event_code_pkg::record_type o_record,
    input wire logic i_rec_ready
);
    import event_code_pkg::*;

    // ------------------------------------------------------------
    // Transition detect and cause encode
    // ------------------------------------------------------------
    line_state_type prev_q;
    line_state_type prev_d;
    logic end_xfer;
    logic [7:0] cause;

    // Remember previous line state
    always_comb begin
        prev_d = i_line_state;
    end

    // Previous-state register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            prev_q <= LINE_OTHER;
        end else begin
            prev_q <= prev_d;
        end
    end

    // Direct move from data transfer into quiet
    assign end_xfer = (prev_q == LINE_DATA_XFER) && (i_line_state == LINE_QUIET);

    // Priority encode of the departure trigger; host requests first
    always_comb begin
        cause = CAUSE_NONE;
        if (i_trigger.co_host) begin
            cause = CAUSE_CO_HOST;
        end else if (i_trigger.remote_host) begin
            cause = CAUSE_REMOTE_HOST;
        end else if (i_trigger.loss_signal) begin
            cause = CAUSE_LOSS_SIGNAL;
        end else if (i_trigger.loss_frame) begin
            cause = CAUSE_LOSS_FRAME;
        end else if (i_trigger.sev_err_sec) begin
            cause = CAUSE_SEV_ERR_SEC;
        end else if (i_trigger.loss_margin) begin
            cause = CAUSE_LOSS_MARGIN;
        end else if (i_trigger.sublayer_sync) begin
            cause = CAUSE_SUBLAYER_SYNC;
        end else if (i_trigger.save_limit) begin
            cause = CAUSE_SAVE_LIMIT;
        end else if (i_trigger.save_timeout) begin
            cause = CAUSE_SAVE_TIMEOUT;
        end else if (i_trigger.overhead_noresp) begin
            cause = CAUSE_OVERHEAD_NORESP;
        end else if (i_reinit_policy == POLICY_ZERO && i_trigger.vend_near_ber) begin
            cause = CAUSE_VEND_NEAR_BER;
        end else if (i_reinit_policy == POLICY_ZERO && i_trigger.vend_far_ber) begin
            cause = CAUSE_VEND_FAR_BER;
        end else if (i_reinit_policy == POLICY_ONE && i_trigger.policy1_ber) begin
            cause = CAUSE_POLICY1_BER;
        end
    end

    // ------------------------------------------------------------
    // Per-type slots
    // ------------------------------------------------------------
    localparam logic [NUM_SRC*8-1:0] TYPE_CODES = {
        EVT_END_XFER, EVT_US_RATE_SAVE, EVT_DS_RATE_SAVE, EVT_US_RATE_ADAPT, EVT_DS_RATE_ADAPT,
        EVT_US_INIT_RATE, EVT_DS_INIT_RATE, EVT_GOOD_INIT, EVT_FAILED_INIT, EVT_PREV_END_XFER
    };

    // Slot interface vectors
    logic [NUM_SRC-1:0] occur;
    logic [NUM_SRC*8-1:0] occur_data;
    logic [NUM_SRC-1:0] pending;
    logic [NUM_SRC*8-1:0] pend_data;
    logic [NUM_SRC-1:0] taken;
    logic [NUM_SRC-1:0] enable;

    // Route inputs; the end-of-transfer slot uses the detector and cause
    always_comb begin
        occur = i_event;
        occur_data = i_event_data;
        occur[SRC_END_XFER] = end_xfer && (cause != CAUSE_NONE);
        occur_data[SRC_END_XFER*8 +: 8] = cause;
        enable = IMPLEMENTED;
    end

    // One slot per event source
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : slots
            event_slot slot (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .i_enable(enable[g]),
                .i_occur(occur[g]),
                .i_data(occur_data[g*8 +: 8]),
                .i_second(i_second_tick),
                .i_taken(taken[g]),
                .o_pending(pending[g]),
                .o_data(pend_data[g*8 +: 8])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Record output
    // ------------------------------------------------------------
    // Record output state
    logic [NUM_SRC-1:0] sel;
    logic [$clog2(NUM_SRC)-1:0] sel_idx;
    logic busy_q;
    logic busy_d;
    logic [7:0] type_code;
    record_type rec_q;
    record_type rec_d;
    logic [STAMP_BYTES*8-1:0] stamp_q;
    logic [STAMP_BYTES*8-1:0] stamp_d;

    // Lowest pending slot wins
    always_comb begin
        sel = '0;
        sel_idx = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pending[i]) begin
                sel_idx = i[$clog2(NUM_SRC)-1:0];
            end
        end
        if (pending != '0 && !busy_q) begin
            sel[sel_idx] = 1'b1;
        end
    end

    // Type lookup; a code in the reserved range never leaves, a dummy goes instead
    always_comb begin
        type_code = TYPE_CODES[sel_idx*8 +: 8];
        if (type_code >= EVT_RESERVED_LO && type_code <= EVT_RESERVED_HI) begin
            type_code = EVT_DUMMY;
        end
    end

    // Load a record, hold until the buffer accepts it
    always_comb begin
        busy_d = busy_q;
        rec_d = rec_q;
        taken = '0;
        stamp_d = i_second_tick ? i_stamp : stamp_q;
        if (busy_q && i_rec_ready) begin
            busy_d = 1'b0;
        end
        if (!busy_q && pending != '0) begin
            busy_d = 1'b1;
            taken = sel;
            rec_d.stamp = stamp_q;
            rec_d.event_type = type_code;
            rec_d.event_data = pend_data[sel_idx*8 +: 8];
        end
    end

    // Record registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            busy_q <= 1'b0;
            rec_q <= '0; // Dummy record at rest
            stamp_q <= '0;
        end else begin
            busy_q <= busy_d;
            rec_q <= rec_d;
            stamp_q <= stamp_d;
        end
    end

    assign o_rec_valid = busy_q;
    assign o_record = rec_q;
endmodule

// file: core/event_slot.sv
// One event-type slot: collapses occurrences within a second into one pending record
module event_slot (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Control
    input wire logic i_enable,
    input wire logic i_occur,
    input wire logic [7:0] i_data,
    input wire logic i_second,
    input wire logic i_taken,
    // Status
    output logic o_pending,
    output logic [7:0] o_data
);
    import event_code_pkg::*;

    logic seen_q;
    logic seen_d;
    logic pend_q;
    logic pend_d;
    logic [7:0] data_q;
    logic [7:0] data_d;
    logic [7:0] pdata_q;
    logic [7:0] pdata_d;

    // Collect during the second, publish at its end, clear on take
    always_comb begin
        seen_d = seen_q;
        data_d = data_q;
        pend_d = pend_q;
        pdata_d = pdata_q;
        if (i_taken) begin
            pend_d = 1'b0;
        end
        if (i_second) begin
            seen_d = 1'b0;
            if (seen_q) begin
                pend_d = 1'b1;
                pdata_d = data_q;
            end
        end
        if (i_enable && i_occur) begin
            if (!seen_d) begin
                data_d = i_data; // First occurrence keeps its data
            end
            seen_d = 1'b1;
        end
    end

    // Slot registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            seen_q <= 1'b0;
            pend_q <= 1'b0;
            data_q <= 8'h00;
            pdata_q <= 8'h00;
        end else begin
            seen_q <= seen_d;
            pend_q <= pend_d;
            data_q <= data_d;
            pdata_q <= pdata_d;
        end
    end

    assign o_pending = pend_q;
    assign o_data = pdata_q;
endmodule

// file: sim/event_buffer_model.sv
// Behavioural model of the event buffer taking six-byte records
module event_buffer_model
    import event_code_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Control and record input
    input wire logic i_stall,
    input wire logic i_rec_valid,
    input wire event_code_pkg::record_type i_record,
    // Accept
    output logic o_rec_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    record_type got[$];

    // Accept whole records; a stall gives ready every other cycle
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_rec_ready <= 1'b0;
        end else begin
            o_rec_ready <= i_stall ? !o_rec_ready : 1'b1;
            if (i_rec_valid && o_rec_ready) begin
                got.push_back(i_record);
            end
        end
    end
endmodule

// file: sim/event_record_code_encoder_asserts.sv
// Checker of the record write port of the event record encoder
module event_record_code_encoder_asserts
    import event_code_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Watched ports
    input wire logic i_reinit_policy,
    input wire logic o_rec_valid,
    input wire event_code_pkg::record_type o_record,
    input wire logic i_rec_ready
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // Reset leaves an all-zero record and no write
    property p_reset;
        $past(i_rst) |-> !o_rec_valid && o_record == '0;
    endproperty
    a_reset: assert property (p_reset) else $error("record not cleared by reset");
    // A refused record stands unchanged
    property p_hold;
        o_rec_valid && !i_rec_ready |=> o_rec_valid && $stable(o_record);
    endproperty
    a_hold: assert property (p_hold) else $error("record changed before accept");
    // One write per record, then a gap
    property p_gap;
        o_rec_valid && i_rec_ready |=> !o_rec_valid;
    endproperty
    a_gap: assert property (p_gap) else $error("no gap after accept");
    // Reserved types never leave
    property p_reserved_type;
        o_rec_valid |-> !(o_record.event_type inside {[8'h11:8'h7F]});
    endproperty
    a_reserved_type: assert property (p_reserved_type) else $error("reserved event type");
    // Only the defined types of this block leave
    property p_types;
        o_rec_valid |-> o_record.event_type inside {[8'h01:8'h06], [8'h0B:8'h0E]};
    endproperty
    a_types: assert property (p_types) else $error("unknown event type");
    // Causes stay within 01 to 0D
    property p_cause_range;
        o_rec_valid && o_record.event_type == 8'h01 |-> o_record.event_data inside {[8'h01:8'h0D]};
    endproperty
    a_cause_range: assert property (p_cause_range) else $error("reserved cause code");
    // Vendor error causes only under policy 0
    property p_policy0;
        o_rec_valid && o_record.event_type == 8'h01 && o_record.event_data inside {8'h0B, 8'h0C}
            |-> !i_reinit_policy;
    endproperty
    a_policy0: assert property (p_policy0) else $error("vendor cause under policy 1");
    // Policy-1 error cause only under policy 1
    property p_policy1;
        o_rec_valid && o_record.event_type == 8'h01 && o_record.event_data == 8'h0D |-> i_reinit_policy;
    endproperty
    a_policy1: assert property (p_policy1) else $error("policy 1 cause under policy 0");
endmodule

bind event_record_code_encoder event_record_code_encoder_asserts CHK (
    .i_clk(i_clk), .i_rst(i_rst), .i_reinit_policy(i_reinit_policy),
    .o_rec_valid(o_rec_valid), .o_record(o_record), .i_rec_ready(i_rec_ready)
);

// file: sim/event_record_code_encoder_tb.sv
// Self-checking bench of the event record encoder
module event_record_code_encoder_tb import event_code_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    line_state_type i_line_state = LINE_OTHER;
    logic i_second_tick = 1'b0;
    logic [STAMP_BYTES*8-1:0] i_stamp = 32'h0;
    logic i_reinit_policy = 1'b0;
    trigger_type i_trigger = '0;
    logic [NUM_SRC-1:0] i_event = '0;
    logic [NUM_SRC*8-1:0] i_event_data = '0;
    logic o_rec_valid;
    record_type o_record;
    logic i_rec_ready;
    logic stall = 1'b0;
    logic opt_valid;
    record_type opt_record;
    int opt_count = 0;
    int opt_other = 0;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;

    event_record_code_encoder DUT (
        .i_clk(i_clk), .i_rst(i_rst), .i_line_state(i_line_state), .i_second_tick(i_second_tick),
        .i_stamp(i_stamp), .i_reinit_policy(i_reinit_policy), .i_trigger(i_trigger), .i_event(i_event),
        .i_event_data(i_event_data), .o_rec_valid(o_rec_valid), .o_record(o_record), .i_rec_ready(i_rec_ready)
    );
    event_buffer_model BUF (
        .i_clk(i_clk), .i_rst(i_rst), .i_stall(stall), .i_rec_valid(o_rec_valid),
        .i_record(o_record), .o_rec_ready(i_rec_ready)
    );
    // Variant with only the end-of-transfer type implemented; its buffer always accepts
    event_record_code_encoder #(.IMPLEMENTED(10'h200)) DUT_OPT (
        .i_clk(i_clk), .i_rst(i_rst), .i_line_state(i_line_state), .i_second_tick(i_second_tick),
        .i_stamp(i_stamp), .i_reinit_policy(i_reinit_policy), .i_trigger(i_trigger), .i_event(i_event),
        .i_event_data(i_event_data), .o_rec_valid(opt_valid), .o_record(opt_record), .i_rec_ready(1'b1)
    );

    // Count the variant's writes by type
    always @(posedge i_clk) begin
        if (opt_valid && opt_record.event_type == EVT_END_XFER) begin
            opt_count <= opt_count + 1;
        end else if (opt_valid) begin
            opt_other <= opt_other + 1;
        end
    end

    // Clock and hang guard
    initial begin
        forever #50 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            final_report();
        end
    end

    // Verdict
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Compare one value
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-second boundary with its stamp
    task automatic tick(input logic [31:0] s);
        @(negedge i_clk);
        i_second_tick = 1'b1;
        i_stamp = s;
        @(negedge i_clk);
        i_second_tick = 1'b0;
    endtask

    // Next record taken by the buffer must match
    task automatic expect_rec(input logic [7:0] t, input logic [7:0] d, input logic [31:0] s);
        record_type r;
        r = 'x;
        for (int k = 0; k < 60 && BUF.got.size() == 0; k++) @(negedge i_clk);
        if (BUF.got.size() != 0) r = BUF.got.pop_front();
        check(r, {s, t, d});
    endtask

    // No record may arrive
    task automatic expect_none();
        repeat (12) @(negedge i_clk);
        check(48'(BUF.got.size()), 48'h0);
        BUF.got.delete();
    endtask

    // Enter a state, then go quiet with the given triggers
    task automatic leave(input line_state_type st, input logic [12:0] tr);
        @(negedge i_clk);
        i_line_state = st;
        @(negedge i_clk);
        i_line_state = LINE_QUIET;
        i_trigger = trigger_type'(tr);
        @(negedge i_clk);
        i_line_state = LINE_OTHER;
        i_trigger = '0;
    endtask

    // All nine strobe sources in one second, repeats, stalling buffer
    task automatic s_types();
        logic [7:0] ty [9] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0B, 8'h0C, 8'h0D, 8'h0E};
        stall = 1'b1;
        @(negedge i_clk);
        for (int i = 0; i < NUM_SRC; i++) i_event_data[i*8+:8] = 8'h20 + 8'(i);
        i_event = '1;
        @(negedge i_clk);
        i_event = 10'h004;
        i_event_data[23:16] = 8'h77;
        @(negedge i_clk);
        i_event = '0;
        tick(32'h100000A5);
        for (int i = 0; i < 9; i++) expect_rec(ty[i], 8'h20 + 8'(i), 32'h100000A5);
        expect_none();
        stall = 1'b0;
    endtask

    // Every cause code, policy set to allow it
    task automatic s_causes();
        for (int i = 1; i <= 13; i++) begin
            i_reinit_policy = (i == 13) ? 1'b1 : (i >= 11) ? 1'b0 : 1'(i % 2);
            leave(LINE_DATA_XFER, 13'h1 << (13 - i));
            tick(32'h20000000 + 32'(i));
            expect_rec(8'h01, 8'(i), 32'h20000000 + 32'(i));
        end
    endtask

    // Gated causes, no cause, indirect move; then many triggers at once
    task automatic s_refused();
        i_reinit_policy = 1'b1;
        leave(LINE_DATA_XFER, 13'h0004);
        leave(LINE_DATA_XFER, 13'h0002);
        leave(LINE_DATA_XFER, 13'h0000);
        leave(LINE_OTHER, 13'h1000);
        i_reinit_policy = 1'b0;
        leave(LINE_DATA_XFER, 13'h0001);
        tick(32'h30000000);
        expect_none();
        leave(LINE_DATA_XFER, 13'h1FFF);
        tick(32'h30000001);
        expect_rec(8'h01, 8'h01, 32'h30000001);
        repeat (2) @(negedge i_clk);
        check(48'(opt_other), 48'h0);
        check(48'(opt_count), 48'hE);
    endtask

    // Main sequence
    initial begin
        repeat (16) @(negedge i_clk);
        i_rst = 1'b0;
        @(negedge i_clk);
        check(o_record, 48'h0);
        check({47'h0, o_rec_valid}, 48'h0);
        s_types();
        s_causes();
        s_refused();
        final_report();
    end
endmodule
